// File: verilog/bcf_pkg.sv
// Constants, frame layouts and types for the breaker feedback framer.
// Functional notes
// - Frames 4 and 5 carry frequency, power, temperatures.
// - Config frame one: 0x14, flags, voltage limits.
// - Config frame two: 0x15, input scale, temperatures.
// - Config frame three: 0x16, current and output scale.
// - Config frame four: 0x18, overcurrent levels low-high.
// - Flag bits 0-3 enable switching and protections.
// - Flag bits 4-6 select DC, 60 Hz, limits.
// - Status bits 0-4 hold operating state code.
// - Status bits 5,6,12,13 report switches and inhibits; bit 7 is the summary error.
// - Status bits 8-11 and 14-17 flag errors.
// - Identifier 0x321, eight data bytes every frame.
// - Command 0x06 returns all status feedback frames.
// - Command 0x13 returns the trip-curve frame.
// - Command 0x14 returns version then configuration frames.
package bcf_pkg;
   // Standard identifier carried by every frame.
   localparam logic [10:0] CAN_ID = 11'h321;
   // Number of data bytes per frame.
   localparam int FRAME_BYTES = 8;
   // Host command codes.
   localparam logic [7:0] CMD_STATUS = 8'h06;
   localparam logic [7:0] CMD_TRIP = 8'h13;
   localparam logic [7:0] CMD_CONFIG = 8'h14;
   // Leading codes of answer frames.
   localparam logic [7:0] CODE_STATUS = 8'h04;
   localparam logic [7:0] CODE_TRIP = 8'h13;
   localparam logic [7:0] CODE_CFG1 = 8'h14;
   localparam logic [7:0] CODE_CFG2 = 8'h15;
   localparam logic [7:0] CODE_CFG3 = 8'h16;
   localparam logic [7:0] CODE_VERSION = 8'h17;
   localparam logic [7:0] CODE_CFG4 = 8'h18;
   // Status feedback frame numbers in this block.
   localparam logic [7:0] STAT_FRAME_A = 8'h04;
   localparam logic [7:0] STAT_FRAME_B = 8'h05;
   // Configuration flag byte bit positions.
   localparam int FLG_ZV_ON = 0;
   localparam int FLG_ZC_OFF = 1;
   localparam int FLG_OC_DET = 2;
   localparam int FLG_OT_PROT = 3;
   localparam int FLG_DC = 4;
   localparam int FLG_60HZ = 5;
   localparam int FLG_LIMITS = 6;
   // Status word bit positions.
   localparam int ST_STATE_LO = 0;
   localparam int ST_STATE_HI = 4;
   localparam int ST_TRANSISTOR = 5;
   localparam int ST_RELAY = 6;
   localparam int ST_ERROR = 7;
   localparam int ST_OVERCURRENT = 8;
   localparam int ST_INPUT_V = 9;
   localparam int ST_OVERLOAD = 10;
   localparam int ST_OVERTEMP = 11;
   localparam int ST_EXT_INH = 12;
   localparam int ST_BP_INH = 13;
   localparam int ST_INTEGRAL = 14;
   localparam int ST_AC15 = 15;
   localparam int ST_SLOW = 16;
   localparam int ST_COOLDOWN = 17;
   localparam int STATUS_W = 18;
   // Operating state codes.
   localparam logic [4:0] OPS_DOWN = 5'h00;
   localparam logic [4:0] OPS_SELFTEST = 5'h01;
   localparam logic [4:0] OPS_STARTUP = 5'h02;
   localparam logic [4:0] OPS_FAILURE = 5'h03;
   localparam logic [4:0] OPS_OFF = 5'h04;
   localparam logic [4:0] OPS_IDLE = 5'h05;
   localparam logic [4:0] OPS_SYNC = 5'h06;
   localparam logic [4:0] OPS_ON = 5'h07;
   localparam logic [4:0] OPS_ZC_SWITCH = 5'h08;
   localparam logic [4:0] OPS_ZC_PROTECT = 5'h09;
   localparam logic [4:0] OPS_PROTECT = 5'h0c;
   localparam logic [4:0] OPS_CRITICAL = 5'h0e;
   localparam logic [4:0] OPS_ZC_FAILURE = 5'h0f;
   localparam logic [4:0] OPS_IDLE_FAILURE = 5'h10;
   // Answer FIFO depth in frames.
   localparam int FIFO_DEPTH = 4;
   // Frame selectors produced by the sequencer.
   typedef enum logic [3:0]
   {
      FRM_STAT_A = 4'h0,
      FRM_STAT_B = 4'h1,
      FRM_TRIP = 4'h2,
      FRM_VERSION = 4'h3,
      FRM_CFG1 = 4'h4,
      FRM_CFG2 = 4'h5,
      FRM_CFG3 = 4'h6,
      FRM_CFG4 = 4'h7
   } bcf_frame_e;
   // Sequencer states, one-hot.
   typedef enum logic [2:0]
   {
      SEQ_IDLE = 3'b001,
      SEQ_EMIT = 3'b010,
      SEQ_WAIT = 3'b100
   } bcf_seq_e;
endpackage : bcf_pkg

// File: verilog/bcf_stream_if.sv
// Valid/ready frame stream carrier between framer and FIFO.
interface bcf_stream_if;
   // Eight frame bytes, byte 0 in the low lane.
   logic [63:0] data;
   // Frame offered.
   logic valid;
   // Frame accepted.
   logic ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface : bcf_stream_if

// File: verilog/bcf_fifo.sv
// Parameterised flip-flop FIFO with valid and ready on both sides.
module bcf_fifo #(
   parameter int WIDTH = 64,
   parameter int DEPTH = 4
)
(
   input wire logic mclk,
   input wire logic rst,
   bcf_stream_if.snk in_s,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);
   // Storage entries addressed by pointer.
   logic [WIDTH-1:0] mem_r [DEPTH];
   // Write and read pointers.
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   // Occupancy count, one wider than the pointers.
   logic [AW:0] cnt_r;
   logic push;
   logic pop;

   // Full and empty come straight from the count, so back-pressure is honest.
   assign in_s.ready = (cnt_r != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
   assign out_valid = (cnt_r != '0);
   assign push = in_s.valid && in_s.ready;
   assign pop = out_valid && out_ready;
   // Output data is the head entry, itself a flip-flop.
   assign out_data = mem_r[rd_ptr_r];

   // Entry writes.
   always_ff @(posedge mclk)
   begin
      if (push)
      begin
         mem_r[wr_ptr_r] <= in_s.data;
      end
   end

   // Pointer and count upkeep.
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         cnt_r <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + AW'(1);
         end
         if (pop)
         begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + AW'(1);
         end
         // Simultaneous push and pop leaves the count unchanged.
         if (push && !pop)
         begin
            cnt_r <= cnt_r + (AW+1)'(1);
         end
         else if (pop && !push)
         begin
            cnt_r <= cnt_r - (AW+1)'(1);
         end
      end
   end
endmodule : bcf_fifo

// File: verilog/bcf_framer.sv
// Top framer: builds answer frames for host readout commands.
module bcf_framer
(
   input wire logic mclk,
   input wire logic rst,
   // Host command byte 0, taken when cmd_valid is high and cmd_ready high.
   input wire logic [7:0] cmd_byte,
   input wire logic cmd_valid,
   output logic cmd_ready,
   // Live measurements.
   input wire logic [15:0] line_frequency,
   input wire logic [15:0] peak_power,
   input wire logic [15:0] temp_sensor_three,
   input wire logic [15:0] temp_sensor_four,
   input wire logic [15:0] overload_usage_percent,
   // Status word sources.
   input wire logic [4:0] operating_state,
   input wire logic transistor_on_state,
   input wire logic relay_on_state,
   input wire logic summary_error,
   input wire logic overcurrent_error,
   input wire logic input_voltage_error,
   input wire logic overload_error,
   input wire logic overtemperature_error,
   input wire logic external_inhibit_line,
   input wire logic backplane_inhibit_line,
   input wire logic integral_overload,
   input wire logic ac15_category_overload,
   input wire logic slow_overload,
   input wire logic post_overload_cooldown,
   // Configuration flags.
   input wire logic zero_voltage_turn_on_enable,
   input wire logic zero_current_turn_off_enable,
   input wire logic overcurrent_detect_enable,
   input wire logic overtemperature_protect_enable,
   input wire logic direct_current_operation,
   input wire logic sixty_hertz_operation,
   input wire logic supply_limit_protect_enable,
   // Configuration values.
   input wire logic [15:0] undervoltage_limit,
   input wire logic [15:0] overvoltage_limit,
   input wire logic [31:0] input_voltage_scale,
   input wire logic [31:0] output_voltage_scale,
   input wire logic [31:0] current_scale,
   input wire logic [7:0] junction_trip_temperature,
   input wire logic [7:0] junction_resume_temperature,
   input wire logic [15:0] negative_overcurrent_level,
   input wire logic [15:0] positive_overcurrent_level,
   // Trip curve values.
   input wire logic [7:0] nominal_current,
   input wire logic [7:0] low_trip_factor,
   input wire logic [7:0] overdrive_time,
   input wire logic [7:0] high_trip_factor,
   input wire logic [15:0] integral_overload_value,
   input wire logic [7:0] static_overdrive_factor,
   // Version values.
   input wire logic [7:0] software_version,
   input wire logic [7:0] software_main_version,
   input wire logic [7:0] software_subversion,
   input wire logic [7:0] board_revision,
   // Frame output toward the CAN controller.
   output logic [10:0] tx_id,
   output logic [3:0] tx_dlc,
   output logic [63:0] tx_data,
   output logic tx_valid,
   input wire logic tx_ready,
   // High while a readout set is being produced or drained.
   output logic busy
);
   // Stream from the builder into the FIFO.
   bcf_stream_if frm_s ();
   // Sequencer state.
   bcf_pkg::bcf_seq_e seq_r;
   // Frame currently being emitted.
   bcf_pkg::bcf_frame_e cur_r;
   // Last frame of the active set.
   bcf_pkg::bcf_frame_e last_r;
   // Assembled frame, held in flip-flops.
   logic [63:0] frame_r;
   // Assembled status word.
   logic [bcf_pkg::STATUS_W-1:0] status_word;
   // Configuration flag byte.
   logic [7:0] flag_byte;
   // Combinational frame content for cur_r.
   logic [63:0] frame_nxt;
   logic fifo_valid;
   logic set_done;

   // Flag byte assembly; bit 7 is unused and reads zero.
   always_comb
   begin
      flag_byte = 8'h00;
      flag_byte[bcf_pkg::FLG_ZV_ON] = zero_voltage_turn_on_enable;
      flag_byte[bcf_pkg::FLG_ZC_OFF] = zero_current_turn_off_enable;
      flag_byte[bcf_pkg::FLG_OC_DET] = overcurrent_detect_enable;
      flag_byte[bcf_pkg::FLG_OT_PROT] = overtemperature_protect_enable;
      flag_byte[bcf_pkg::FLG_DC] = direct_current_operation;
      flag_byte[bcf_pkg::FLG_60HZ] = sixty_hertz_operation;
      flag_byte[bcf_pkg::FLG_LIMITS] = supply_limit_protect_enable;
   end

   // Status word assembly from the live state sources.
   always_comb
   begin
      status_word = '0;
      status_word[bcf_pkg::ST_STATE_HI:bcf_pkg::ST_STATE_LO] = operating_state;
      status_word[bcf_pkg::ST_TRANSISTOR] = transistor_on_state;
      status_word[bcf_pkg::ST_RELAY] = relay_on_state;
      status_word[bcf_pkg::ST_ERROR] = summary_error;
      status_word[bcf_pkg::ST_EXT_INH] = external_inhibit_line;
      status_word[bcf_pkg::ST_BP_INH] = backplane_inhibit_line;
      status_word[bcf_pkg::ST_OVERCURRENT] = overcurrent_error;
      status_word[bcf_pkg::ST_INPUT_V] = input_voltage_error;
      status_word[bcf_pkg::ST_OVERLOAD] = overload_error;
      status_word[bcf_pkg::ST_OVERTEMP] = overtemperature_error;
      status_word[bcf_pkg::ST_INTEGRAL] = integral_overload;
      status_word[bcf_pkg::ST_AC15] = ac15_category_overload;
      status_word[bcf_pkg::ST_SLOW] = slow_overload;
      status_word[bcf_pkg::ST_COOLDOWN] = post_overload_cooldown;
   end

   // Frame content per selector. Byte 0 is lane [7:0]; pairs go low byte first
   // while of the status word only bits 17:16 are placed, in the two lowest bits of byte 6 of status frame A.
   always_comb
   begin
      frame_nxt = 64'h0;
      case (cur_r)
         bcf_pkg::FRM_STAT_A:
         begin
            frame_nxt = {14'h0000, status_word[bcf_pkg::ST_COOLDOWN:bcf_pkg::ST_SLOW], peak_power,
               line_frequency, bcf_pkg::STAT_FRAME_A, bcf_pkg::CODE_STATUS};
         end
         bcf_pkg::FRM_STAT_B:
         begin
            frame_nxt = {overload_usage_percent, temp_sensor_four, temp_sensor_three,
               bcf_pkg::STAT_FRAME_B, bcf_pkg::CODE_STATUS};
         end
         bcf_pkg::FRM_TRIP:
         begin
            frame_nxt = {static_overdrive_factor, integral_overload_value, high_trip_factor,
               overdrive_time, low_trip_factor, nominal_current, bcf_pkg::CODE_TRIP};
         end
         bcf_pkg::FRM_VERSION:
         begin
            frame_nxt = {24'h000000, board_revision, software_subversion,
               software_main_version, software_version, bcf_pkg::CODE_VERSION};
         end
         bcf_pkg::FRM_CFG1:
         begin
            frame_nxt = {16'h0000, overvoltage_limit[15:8], overvoltage_limit[7:0],
               undervoltage_limit[15:8], undervoltage_limit[7:0], flag_byte,
               bcf_pkg::CODE_CFG1};
         end
         bcf_pkg::FRM_CFG2:
         begin
            frame_nxt = {output_voltage_scale[7:0], junction_resume_temperature,
               junction_trip_temperature, input_voltage_scale, bcf_pkg::CODE_CFG2};
         end
         bcf_pkg::FRM_CFG3:
         begin
            frame_nxt = {output_voltage_scale[31:8], current_scale, bcf_pkg::CODE_CFG3};
         end
         bcf_pkg::FRM_CFG4:
         begin
            frame_nxt = {24'h000000, positive_overcurrent_level[15:8],
               positive_overcurrent_level[7:0], negative_overcurrent_level[15:8],
               negative_overcurrent_level[7:0], bcf_pkg::CODE_CFG4};
         end
         default:
         begin
            frame_nxt = 64'h0;
         end
      endcase
   end

   // A command is taken only while idle; anything else waits on cmd_ready.
   assign cmd_ready = (seq_r == bcf_pkg::SEQ_IDLE);
   assign set_done = (cur_r == last_r);
   assign frm_s.data = frame_r;
   assign frm_s.valid = (seq_r == bcf_pkg::SEQ_WAIT);

   // Sequencer: capture a frame, push it, advance in ascending order.
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         seq_r <= bcf_pkg::SEQ_IDLE;
         cur_r <= bcf_pkg::FRM_STAT_A;
         last_r <= bcf_pkg::FRM_STAT_A;
      end
      else
      begin
         case (seq_r)
            bcf_pkg::SEQ_IDLE:
            begin
               if (cmd_valid)
               begin
                  if (cmd_byte == bcf_pkg::CMD_STATUS)
                  begin
                     cur_r <= bcf_pkg::FRM_STAT_A;
                     last_r <= bcf_pkg::FRM_STAT_B;
                     seq_r <= bcf_pkg::SEQ_EMIT;
                  end
                  else if (cmd_byte == bcf_pkg::CMD_TRIP)
                  begin
                     cur_r <= bcf_pkg::FRM_TRIP;
                     last_r <= bcf_pkg::FRM_TRIP;
                     seq_r <= bcf_pkg::SEQ_EMIT;
                  end
                  else if (cmd_byte == bcf_pkg::CMD_CONFIG)
                  begin
                     cur_r <= bcf_pkg::FRM_VERSION;
                     last_r <= bcf_pkg::FRM_CFG4;
                     seq_r <= bcf_pkg::SEQ_EMIT;
                  end
               end
            end
            bcf_pkg::SEQ_EMIT:
            begin
               seq_r <= bcf_pkg::SEQ_WAIT;
            end
            bcf_pkg::SEQ_WAIT:
            begin
               // The FIFO's ready stalls us here, so a slow CAN side holds the set.
               if (frm_s.ready)
               begin
                  if (set_done)
                  begin
                     seq_r <= bcf_pkg::SEQ_IDLE;
                  end
                  else
                  begin
                     cur_r <= bcf_pkg::bcf_frame_e'(cur_r + 4'h1);
                     seq_r <= bcf_pkg::SEQ_EMIT;
                  end
               end
            end
            default:
            begin
               seq_r <= bcf_pkg::SEQ_IDLE;
            end
         endcase
      end
   end

   // Frame register: sampled once per frame so its bytes are coherent.
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         frame_r <= 64'h0;
      end
      else if (seq_r == bcf_pkg::SEQ_EMIT)
      begin
         frame_r <= frame_nxt;
      end
   end

   // Answer buffer between the builder and the CAN controller.
   bcf_fifo #(
      .WIDTH(64),
      .DEPTH(bcf_pkg::FIFO_DEPTH)
   ) bcf_fifo_i (
      .mclk(mclk),
      .rst(rst),
      .in_s(frm_s),
      .out_data(tx_data),
      .out_valid(fifo_valid),
      .out_ready(tx_ready)
   );

   assign tx_id = bcf_pkg::CAN_ID;
   assign tx_dlc = 4'(bcf_pkg::FRAME_BYTES);
   assign tx_valid = fifo_valid;
   assign busy = (seq_r != bcf_pkg::SEQ_IDLE) || fifo_valid;
endmodule : bcf_framer

// File: bench/bcf_framer_monitor.sv
// Port-level concurrent checks for the feedback framer.
module bcf_framer_monitor
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] cmd_byte,
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire logic [10:0] tx_id,
   input wire logic [3:0] tx_dlc,
   input wire logic [63:0] tx_data,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic busy
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   // A command taken while the block is fully quiet, so answer latency is fixed.
   sequence s_take(logic [7:0] code);
      cmd_valid && cmd_ready && !busy && cmd_byte == code;
   endsequence
   // A frame on offer with the given first two bytes.
   sequence s_head(logic [15:0] head);
      tx_valid && tx_data[15:0] == head;
   endsequence
   property p_frame_form;
      tx_valid |-> tx_id == 11'h321 && tx_dlc == 4'h8;
   endproperty
   property p_hold;
      tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
   endproperty
   property p_trip_answer;
      s_take(8'h13) |-> ##3 (tx_valid && tx_data[7:0] == 8'h13);
   endproperty
   property p_status_answer;
      s_take(8'h06) |-> ##3 s_head(16'h0404);
   endproperty
   property p_config_answer;
      s_take(8'h14) |-> ##3 (tx_valid && tx_data[7:0] == 8'h17);
   endproperty
   property p_status_order;
      s_head(16'h0404) ##0 tx_ready |-> ##[1:4] s_head(16'h0504);
   endproperty
   property p_quiet;
      !busy && !(cmd_valid && cmd_ready) |=> !tx_valid;
   endproperty
   property p_refuse;
      !cmd_ready |-> busy;
   endproperty
   property p_status_tail;
      s_head(16'h0404) |-> tx_data[63:58] == 6'h00;
   endproperty
   property p_cfg4_tail;
      tx_valid && tx_data[7:0] == 8'h18 |-> tx_data[63:40] == 24'h0;
   endproperty
   a_frame_form: assert property (p_frame_form) else $error("bad id or length");
   a_hold: assert property (p_hold) else $error("frame changed while stalled");
   a_trip_answer: assert property (p_trip_answer) else $error("no trip frame");
   a_status_answer: assert property (p_status_answer) else $error("no status frame");
   a_config_answer: assert property (p_config_answer) else $error("no version frame");
   a_status_order: assert property (p_status_order) else $error("status order");
   a_quiet: assert property (p_quiet) else $error("unrequested frame");
   a_refuse: assert property (p_refuse) else $error("refusing while idle");
   a_status_tail: assert property (p_status_tail) else $error("status tail not zero");
   a_cfg4_tail: assert property (p_cfg4_tail) else $error("config four tail");
endmodule : bcf_framer_monitor

bind bcf_framer bcf_framer_monitor bcf_framer_monitor_i (.mclk(mclk), .rst(rst),
   .cmd_byte(cmd_byte), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .tx_id(tx_id),
   .tx_dlc(tx_dlc), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .busy(busy));

// File: bench/bcf_can_sink.sv
// Behavioural CAN controller that takes finished frames from the framer.
module bcf_can_sink
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [1:0] pace,
   output logic tx_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   // Alternates so the slow pace takes a frame only every other cycle.
   logic phase_r;
   initial tx_ready = 1'b0;
   // Ready moves at the falling edge, away from the framer's sampling edge.
   always @(negedge mclk)
   begin
      phase_r <= rst ? 1'b0 : !phase_r;
      case (pace)
         2'h0: tx_ready <= 1'b1;
         2'h1: tx_ready <= phase_r;
         default: tx_ready <= 1'b0;
      endcase
   end
endmodule : bcf_can_sink

// File: bench/bcf_framer_bench.sv
// Self-checking bench for the feedback framer.
module bcf_framer_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, rst, cmd_valid, cmd_ready, tx_valid, tx_ready, busy;
   logic [7:0] cmd_byte;
   logic [10:0] tx_id;
   logic [3:0] tx_dlc;
   logic [63:0] tx_data;
   logic [1:0] pace;
   // Randomised inputs, refreshed only while the block is idle.
   logic [15:0] line_frequency, peak_power, temp_sensor_three, temp_sensor_four;
   logic [15:0] overload_usage_percent, undervoltage_limit, overvoltage_limit;
   logic [15:0] negative_overcurrent_level, positive_overcurrent_level, integral_overload_value;
   logic [4:0] operating_state;
   logic transistor_on_state, relay_on_state, summary_error, overcurrent_error;
   logic input_voltage_error, overload_error, overtemperature_error, external_inhibit_line;
   logic backplane_inhibit_line, integral_overload, ac15_category_overload, slow_overload;
   logic post_overload_cooldown, zero_voltage_turn_on_enable, zero_current_turn_off_enable;
   logic overcurrent_detect_enable, overtemperature_protect_enable, direct_current_operation;
   logic sixty_hertz_operation, supply_limit_protect_enable;
   logic [31:0] input_voltage_scale, output_voltage_scale, current_scale, seed;
   logic [7:0] junction_trip_temperature, junction_resume_temperature, nominal_current;
   logic [7:0] low_trip_factor, overdrive_time, high_trip_factor, static_overdrive_factor;
   logic [7:0] software_version, software_main_version, software_subversion, board_revision;
   logic [368:0] pool;
   logic [63:0] expected[$];
   logic [7:0] codes [0:2] = '{8'h06, 8'h13, 8'h14};
   int mismatches, n_tests;
   bcf_framer bcf_framer_i (.mclk, .rst, .cmd_byte, .cmd_valid, .cmd_ready, .line_frequency,
      .peak_power, .temp_sensor_three, .temp_sensor_four, .overload_usage_percent,
      .operating_state, .transistor_on_state, .relay_on_state, .summary_error,
      .overcurrent_error, .input_voltage_error, .overload_error, .overtemperature_error,
      .external_inhibit_line, .backplane_inhibit_line, .integral_overload,
      .ac15_category_overload, .slow_overload, .post_overload_cooldown,
      .zero_voltage_turn_on_enable, .zero_current_turn_off_enable, .overcurrent_detect_enable,
      .overtemperature_protect_enable, .direct_current_operation, .sixty_hertz_operation,
      .supply_limit_protect_enable, .undervoltage_limit, .overvoltage_limit,
      .input_voltage_scale, .output_voltage_scale, .current_scale, .junction_trip_temperature,
      .junction_resume_temperature, .negative_overcurrent_level, .positive_overcurrent_level,
      .nominal_current, .low_trip_factor, .overdrive_time, .high_trip_factor,
      .integral_overload_value, .static_overdrive_factor, .software_version,
      .software_main_version, .software_subversion, .board_revision, .tx_id, .tx_dlc,
      .tx_data, .tx_valid, .tx_ready, .busy);
   bcf_can_sink bcf_can_sink_i (.mclk(mclk), .rst(rst), .pace(pace), .tx_ready(tx_ready));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic fail(input string msg);
      mismatches++;
      $display("mismatch at %0t: %s", $time, msg);
   endtask : fail
   task automatic check_frame(input logic [63:0] exp, input logic [63:0] got);
      n_tests++;
      if (got !== exp)
         fail($sformatf("frame %h, expected %h", got, exp));
   endtask : check_frame
   task automatic check_flag(input logic got, input logic exp, input string what);
      n_tests++;
      if (got !== exp)
         fail(what);
   endtask : check_flag
   task automatic print_verdict;
      $display("mismatches %0d, comparisons %0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : print_verdict
   // Fresh random values on every input; a constant field could hide a swapped byte.
   task automatic new_inputs;
      for (int i = 0; i < 369; i++)
      begin
         seed = lfsr(seed);
         pool = {pool[367:0], seed[0]};
      end
      {line_frequency, peak_power, temp_sensor_three, temp_sensor_four, overload_usage_percent,
         operating_state, transistor_on_state, relay_on_state, summary_error, overcurrent_error,
         input_voltage_error, overload_error, overtemperature_error, external_inhibit_line,
         backplane_inhibit_line, integral_overload, ac15_category_overload, slow_overload,
         post_overload_cooldown, zero_voltage_turn_on_enable, zero_current_turn_off_enable,
         overcurrent_detect_enable, overtemperature_protect_enable, direct_current_operation,
         sixty_hertz_operation, supply_limit_protect_enable, undervoltage_limit,
         overvoltage_limit, input_voltage_scale, output_voltage_scale, current_scale,
         junction_trip_temperature, junction_resume_temperature, negative_overcurrent_level,
         positive_overcurrent_level, nominal_current, low_trip_factor, overdrive_time,
         high_trip_factor, integral_overload_value, static_overdrive_factor, software_version,
         software_main_version, software_subversion, board_revision} = pool;
   endtask : new_inputs
   // Notes the frames a command must produce, in the order they must appear.
   task automatic issue(input logic [7:0] code);
      if (code == 8'h06)
      begin
         expected.push_back({14'h0, post_overload_cooldown, slow_overload, peak_power,
            line_frequency, 16'h0404});
         expected.push_back({overload_usage_percent, temp_sensor_four, temp_sensor_three,
            16'h0504});
      end
      if (code == 8'h13)
         expected.push_back({static_overdrive_factor, integral_overload_value,
            high_trip_factor, overdrive_time, low_trip_factor, nominal_current, 8'h13});
      if (code == 8'h14)
      begin
         expected.push_back({24'h0, board_revision, software_subversion,
            software_main_version, software_version, 8'h17});
         expected.push_back({16'h0, overvoltage_limit, undervoltage_limit, 1'b0,
            supply_limit_protect_enable, sixty_hertz_operation, direct_current_operation,
            overtemperature_protect_enable, overcurrent_detect_enable,
            zero_current_turn_off_enable, zero_voltage_turn_on_enable, 8'h14});
         expected.push_back({output_voltage_scale[7:0], junction_resume_temperature,
            junction_trip_temperature, input_voltage_scale, 8'h15});
         expected.push_back({output_voltage_scale[31:8], current_scale, 8'h16});
         expected.push_back({24'h0, positive_overcurrent_level, negative_overcurrent_level,
            8'h18});
      end
      cmd_byte = code;
      cmd_valid = 1'b1;
      @(negedge mclk);
      cmd_valid = 1'b0;
   endtask : issue
   // Bounded wait for the set to drain; a hang ends the run.
   task automatic wait_idle;
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 300)
      begin
         @(negedge mclk);
         n++;
      end
      if (busy !== 1'b0)
      begin
         fail("framer never went idle");
         print_verdict();
      end
   endtask : wait_idle
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // Every accepted frame is matched against the oldest note.
   always @(posedge mclk)
      if (!rst && tx_valid === 1'b1 && tx_ready === 1'b1)
      begin
         check_flag(tx_id === 11'h321 && tx_dlc === 4'h8, 1'b1, "id or length");
         if (expected.size() == 0)
            fail("frame nobody asked for");
         else
            check_frame(expected.pop_front(), tx_data);
      end
   initial
   begin
      rst = 1'b1;
      cmd_valid = 1'b0;
      cmd_byte = 8'h00;
      pace = 2'h0;
      seed = 32'h3;
      pool = '0;
      mismatches = 0;
      n_tests = 0;
      new_inputs();
      repeat (6) @(negedge mclk);
      rst = 1'b0;
      check_flag(busy, 1'b0, "busy after reset");
      foreach (codes[k])
      begin
         issue(codes[k]);
         wait_idle();
      end
      // An unknown code must stay unanswered.
      issue(8'h05);
      repeat (10) @(negedge mclk);
      // Stalled sink fills the FIFO; a command offered meanwhile is refused.
      pace = 2'h2;
      issue(8'h14);
      repeat (14) @(negedge mclk);
      check_flag(cmd_ready, 1'b0, "command taken while full");
      check_flag(tx_valid, 1'b1, "no frame held while stalled");
      cmd_byte = 8'h13;
      cmd_valid = 1'b1;
      repeat (3) @(negedge mclk);
      cmd_valid = 1'b0;
      pace = 2'h1;
      wait_idle();
      repeat (12)
      begin
         new_inputs();
         pace = {1'b0, seed[2]};
         issue(codes[seed[5:4] % 3]);
         wait_idle();
      end
      repeat (4) @(negedge mclk);
      check_flag(expected.size() == 0, 1'b1, "frames missing");
      print_verdict();
   end
endmodule : bcf_framer_bench
